/* File: core/fas_pkg.sv */
package fas_pkg;
    // Slice geometry
    localparam int unsigned WIDTH      = 4;
    localparam int unsigned DEPTH      = 16;
    localparam int unsigned ADDR_W     = 4;
    localparam int unsigned CODE_W     = 3;

    // Operand pair codes: (left, right)
    localparam logic [2:0] SRC_A_ACC   = 3'h0;
    localparam logic [2:0] SRC_A_B     = 3'h1;
    localparam logic [2:0] SRC_Z_ACC   = 3'h2;
    localparam logic [2:0] SRC_Z_B     = 3'h3;
    localparam logic [2:0] SRC_Z_A     = 3'h4;
    localparam logic [2:0] SRC_D_A     = 3'h5;
    localparam logic [2:0] SRC_D_ACC   = 3'h6;
    localparam logic [2:0] SRC_D_Z     = 3'h7;

    // Function codes
    localparam logic [2:0] FN_ADD            = 3'h0;
    localparam logic [2:0] REVERSE_SUBTRACT  = 3'h1;
    localparam logic [2:0] FORWARD_SUBTRACT  = 3'h2;
    localparam logic [2:0] FN_OR             = 3'h3;
    localparam logic [2:0] FN_AND            = 3'h4;
    localparam logic [2:0] INVERTED_LEFT_AND = 3'h5;
    localparam logic [2:0] EXCLUSIVE_OR_FN   = 3'h6;
    localparam logic [2:0] EXCLUSIVE_NOR_FN  = 3'h7;

    // Destination codes
    localparam logic [2:0] LOAD_ACC_ONLY         = 3'h0;
    localparam logic [2:0] DEST_NO_LOAD          = 3'h1;
    localparam logic [2:0] LOAD_FILE_SHOW_PORT   = 3'h2;
    localparam logic [2:0] LOAD_FILE_SHOW_RESULT = 3'h3;
    localparam logic [2:0] BOTH_SHIFT_DOWN       = 3'h4;
    localparam logic [2:0] FILE_SHIFT_DOWN       = 3'h5;
    localparam logic [2:0] BOTH_SHIFT_UP         = 3'h6;
    localparam logic [2:0] FILE_SHIFT_UP         = 3'h7;

    // Register port
    localparam int unsigned REG_AW     = 2;
    localparam int unsigned REG_DW     = 8;
    localparam logic [1:0] OFS_STATUS  = 2'h0;
    localparam logic [1:0] OFS_MASK    = 2'h1;
    localparam logic [1:0] OFS_STATE   = 2'h2;

    // Event bits, shared by status and mask
    localparam int unsigned EV_N       = 3;
    localparam int unsigned EV_OVR     = 0;
    localparam int unsigned EV_ZERO    = 1;
    localparam int unsigned EV_CARRY   = 2;
    localparam logic [2:0] EV_RESET    = 3'h0;
    localparam logic [3:0] WORD_RESET  = 4'h0;
endpackage : fas_pkg

/* File: core/fas_slice.sv */
`timescale 1ns/1ps
module fas_slice (
    input  wire logic       CLK,                // 200 MHz clock
    input  wire logic       RST_N,              // Async reset, active low
    input  wire logic [2:0] SOURCE_SELECT,      // Operand pair code
    input  wire logic [2:0] FUNCTION_SELECT,    // ALU function code
    input  wire logic [2:0] DESTINATION_SELECT, // Destination code
    input  wire logic [3:0] FIRST_READ_ADDR,    // First read port index
    input  wire logic [3:0] SECOND_ADDR,        // Second port and write index
    input  wire logic [3:0] DIRECT_DATA_IN,     // Direct operand
    input  wire logic       CARRY_IN,           // Carry in, active high
    input  wire logic       OUT_ENABLE_N,       // Result bus enable, active low
    output logic      [3:0] RESULT_O,           // Result bus value
    output logic            RESULT_OE,          // Result bus drive enable
    output logic            CARRY_OUT,          // Carry out, active high
    output logic            GENERATE_N,         // Carry generate, active low
    output logic            PROPAGATE_N,        // Carry propagate, active low
    output logic            OVERFLOW_FLAG,      // Two's complement overflow
    output logic            SIGN_BIT,           // Result MSB
    input  wire logic       ZERO_DETECT_I,      // Wired zero line level
    output logic            ZERO_DETECT_O,      // Always low when driven
    output logic            ZERO_DETECT_OE,     // Pulls line low on nonzero
    input  wire logic       RAM_SHIFT_LSB_I,    // File shifter low end in
    output logic            RAM_SHIFT_LSB_O,    // File shifter low end out
    output logic            RAM_SHIFT_LSB_OE,   // File shifter low end drive
    input  wire logic       RAM_SHIFT_MSB_I,    // File shifter high end in
    output logic            RAM_SHIFT_MSB_O,    // File shifter high end out
    output logic            RAM_SHIFT_MSB_OE,   // File shifter high end drive
    input  wire logic       ACC_SHIFT_LSB_I,    // Accumulator low end in
    output logic            ACC_SHIFT_LSB_O,    // Accumulator low end out
    output logic            ACC_SHIFT_LSB_OE,   // Accumulator low end drive
    input  wire logic       ACC_SHIFT_MSB_I,    // Accumulator high end in
    output logic            ACC_SHIFT_MSB_O,    // Accumulator high end out
    output logic            ACC_SHIFT_MSB_OE,   // Accumulator high end drive
    input  wire logic [1:0] REG_ADDR,           // Register index
    input  wire logic [7:0] REG_WDATA,          // Register write data
    input  wire logic       REG_WR,             // Write strobe
    input  wire logic       REG_RD,             // Read strobe
    output logic      [7:0] REG_RDATA,          // Read data, cycle after strobe
    output logic            IRQ                 // Level interrupt
);
    // All clocked state of the slice except the two reset release flops
    typedef struct packed {
        logic [15:0][3:0] file;
        logic [3:0]       acc;
        logic [3:0]       result;
        logic             result_oe;
        logic             sign;
        logic             overflow_flag;
        logic             zero_oe;
        logic [2:0]       status;
        logic [2:0]       mask;
        logic [7:0]       rdata;
        logic             irq;
    } fas_state_t;

    fas_state_t st;
    fas_state_t next_st;
    logic       rst_meta;
    logic       rst_n;

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Read ports; the write lands at the edge, so reads in a cycle see old data
    logic [3:0] port_a;
    logic [3:0] port_b;
    assign port_a = st.file[FIRST_READ_ADDR];
    assign port_b = st.file[SECOND_ADDR];

    // Operand selection; an inhibited input reads as zero
    logic [3:0] r;
    logic [3:0] s;
    always_comb begin
        r = fas_pkg::WORD_RESET;
        s = fas_pkg::WORD_RESET;
        case (SOURCE_SELECT)
            fas_pkg::SRC_A_ACC: begin r = port_a;         s = st.acc; end
            fas_pkg::SRC_A_B:   begin r = port_a;         s = port_b; end
            fas_pkg::SRC_Z_ACC: begin                     s = st.acc; end
            fas_pkg::SRC_Z_B:   begin                     s = port_b; end
            fas_pkg::SRC_Z_A:   begin                     s = port_a; end
            fas_pkg::SRC_D_A:   begin r = DIRECT_DATA_IN; s = port_a; end
            fas_pkg::SRC_D_ACC: begin r = DIRECT_DATA_IN; s = st.acc; end
            fas_pkg::SRC_D_Z:   begin r = DIRECT_DATA_IN;             end
            default:            begin                                 end
        endcase
    end

    // Subtracts complement one operand; carry in supplies the plus one
    logic [3:0] re;
    logic [3:0] se;
    logic [3:0] g;
    logic [3:0] p;
    logic [4:0] c;
    assign re = (FUNCTION_SELECT == fas_pkg::REVERSE_SUBTRACT) ? ~r : r;
    assign se = (FUNCTION_SELECT == fas_pkg::FORWARD_SUBTRACT) ? ~s : s;
    assign c[0] = CARRY_IN;

    // Per-bit generate, propagate and ripple of the carry
    for (genvar i = 0; i < fas_pkg::WIDTH; i++) begin : g_bit
        assign g[i]   = re[i] & se[i];
        assign p[i]   = re[i] | se[i];
        assign c[i+1] = g[i] | (p[i] & c[i]);
    end

    // Result; only the arithmetic codes look at the carry chain
    logic [3:0] f;
    always_comb begin
        case (FUNCTION_SELECT)
            fas_pkg::FN_ADD,
            fas_pkg::REVERSE_SUBTRACT,
            fas_pkg::FORWARD_SUBTRACT:  f = re ^ se ^ c[3:0];
            fas_pkg::FN_OR:             f = r | s;
            fas_pkg::FN_AND:            f = r & s;
            fas_pkg::INVERTED_LEFT_AND: f = ~r & s;
            fas_pkg::EXCLUSIVE_OR_FN:   f = r ^ s;
            fas_pkg::EXCLUSIVE_NOR_FN:  f = ~(r ^ s);
            default:                    f = fas_pkg::WORD_RESET;
        endcase
    end

    // Cascade pins stay combinational so neighbours settle in one cycle
    assign CARRY_OUT   = c[4];
    assign PROPAGATE_N = ~&p;
    assign GENERATE_N  = ~(g[3] | (p[3] & g[2]) | (&p[3:2] & g[1]) | (&p[3:1] & g[0]));

    // Shift pin drivers follow the destination code directly
    logic up;
    logic down;
    assign up   = DESTINATION_SELECT inside {fas_pkg::BOTH_SHIFT_UP, fas_pkg::FILE_SHIFT_UP};
    assign down = DESTINATION_SELECT inside {fas_pkg::BOTH_SHIFT_DOWN, fas_pkg::FILE_SHIFT_DOWN};
    assign RAM_SHIFT_MSB_OE = up;
    assign RAM_SHIFT_MSB_O  = f[3];
    assign RAM_SHIFT_LSB_OE = down;
    assign RAM_SHIFT_LSB_O  = f[0];
    assign ACC_SHIFT_MSB_OE = (DESTINATION_SELECT == fas_pkg::BOTH_SHIFT_UP);
    assign ACC_SHIFT_MSB_O  = st.acc[3];
    assign ACC_SHIFT_LSB_OE = (DESTINATION_SELECT == fas_pkg::BOTH_SHIFT_DOWN);
    assign ACC_SHIFT_LSB_O  = st.acc[0];

    // Registered status outputs
    assign RESULT_O       = st.result;
    assign RESULT_OE      = st.result_oe;
    assign SIGN_BIT       = st.sign;
    assign OVERFLOW_FLAG  = st.overflow_flag;
    assign ZERO_DETECT_OE = st.zero_oe;
    assign ZERO_DETECT_O  = 1'b0; // Open collector only ever pulls low
    assign REG_RDATA      = st.rdata;
    assign IRQ            = st.irq;

    // Next-state logic: file, accumulator, bus, flags and registers
    logic [3:0] file_wdata;
    logic       file_we;
    logic [2:0] events;
    logic       ovr_now;
    assign ovr_now = c[3] ^ c[4];
    always_comb begin
        next_st    = st;
        file_we    = 1'b1;
        file_wdata = f;
        case (DESTINATION_SELECT)
            fas_pkg::LOAD_ACC_ONLY: begin
                file_we    = 1'b0;
                next_st.acc = f;
            end
            fas_pkg::DEST_NO_LOAD: file_we = 1'b0;
            fas_pkg::LOAD_FILE_SHOW_PORT,
            fas_pkg::LOAD_FILE_SHOW_RESULT: file_wdata = f;
            fas_pkg::BOTH_SHIFT_DOWN: begin
                file_wdata  = {RAM_SHIFT_MSB_I, f[3:1]};
                next_st.acc = {ACC_SHIFT_MSB_I, st.acc[3:1]};
            end
            fas_pkg::FILE_SHIFT_DOWN: file_wdata = {RAM_SHIFT_MSB_I, f[3:1]};
            fas_pkg::BOTH_SHIFT_UP: begin
                file_wdata  = {f[2:0], RAM_SHIFT_LSB_I};
                next_st.acc = {st.acc[2:0], ACC_SHIFT_LSB_I};
            end
            fas_pkg::FILE_SHIFT_UP: file_wdata = {f[2:0], RAM_SHIFT_LSB_I};
            default: file_we = 1'b0;
        endcase
        if (file_we) begin
            next_st.file[SECOND_ADDR] = file_wdata;
        end
        // Bus mux and enable
        next_st.result    = (DESTINATION_SELECT == fas_pkg::LOAD_FILE_SHOW_PORT) ? port_a : f;
        next_st.result_oe = ~OUT_ENABLE_N;
        next_st.sign      = f[3];
        next_st.overflow_flag       = ovr_now;
        next_st.zero_oe   = |f;
        // Sticky events; a new event beats a write-one clear in the same cycle
        events                   = fas_pkg::EV_RESET;
        events[fas_pkg::EV_OVR]  = ovr_now;
        events[fas_pkg::EV_ZERO] = ZERO_DETECT_I;
        events[fas_pkg::EV_CARRY] = c[4];
        if (REG_WR && REG_ADDR == fas_pkg::OFS_STATUS) begin
            next_st.status = st.status & ~REG_WDATA[2:0];
        end
        if (REG_WR && REG_ADDR == fas_pkg::OFS_MASK) begin
            next_st.mask = REG_WDATA[2:0];
        end
        next_st.status = next_st.status | events;
        next_st.irq    = |(next_st.status & next_st.mask);
        // Read data live one cycle; unmapped indices read zero
        next_st.rdata = 8'h00;
        if (REG_RD) begin
            case (REG_ADDR)
                fas_pkg::OFS_STATUS: next_st.rdata = {5'h00, st.status};
                fas_pkg::OFS_MASK:   next_st.rdata = {5'h00, st.mask};
                fas_pkg::OFS_STATE:  next_st.rdata = {st.sign, st.overflow_flag, ~st.zero_oe, 1'b0, st.acc};
                default:             next_st.rdata = 8'h00;
            endcase
        end
    end

    // State register
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!rst_n);

    chk_same_ports: assert property (FIRST_READ_ADDR == SECOND_ADDR |-> port_a == port_b)
        else $error("ports differ on equal addresses");
    chk_file_write: assert property (DESTINATION_SELECT >= fas_pkg::LOAD_FILE_SHOW_PORT
        |=> st.file[$past(SECOND_ADDR)] == $past(file_wdata))
        else $error("file word not written");

    chk_file_keep: assert property (DESTINATION_SELECT < fas_pkg::LOAD_FILE_SHOW_PORT
        |=> $stable(st.file))
        else $error("file changed without load");

    chk_acc_load: assert property (DESTINATION_SELECT == fas_pkg::LOAD_ACC_ONLY
        |=> st.acc == $past(f))
        else $error("accumulator missed result");

    chk_acc_down: assert property (DESTINATION_SELECT == fas_pkg::BOTH_SHIFT_DOWN
        ##1 DESTINATION_SELECT == fas_pkg::DEST_NO_LOAD
        |-> st.acc == {$past(ACC_SHIFT_MSB_I), $past(st.acc[3:1])})
        else $error("accumulator down shift wrong");
    chk_bus_mux: assert property (1'b1 |=> RESULT_O ==
        ($past(DESTINATION_SELECT) == fas_pkg::LOAD_FILE_SHOW_PORT ? $past(port_a) : $past(f)))
        else $error("result bus source wrong");

    chk_bus_float: assert property (OUT_ENABLE_N |=> !RESULT_OE)
        else $error("bus driven while disabled");

    chk_zero_det: assert property (1'b1 |=> ZERO_DETECT_OE == ($past(f) != 4'h0))
        else $error("zero detect wrong");

    chk_ovr_flag: assert property (1'b1 |=> OVERFLOW_FLAG == ($past(c[3]) != $past(c[4])))
        else $error("overflow flag wrong");

    chk_sign_bit: assert property (1'b1 |=> SIGN_BIT == $past(f[3]))
        else $error("sign bit wrong");

    chk_add_sum: assert property (FUNCTION_SELECT == fas_pkg::FN_ADD
        |-> {CARRY_OUT, f} == {1'b0, r} + {1'b0, s} + 5'(CARRY_IN))
        else $error("sum wrong");
    chk_logic_cin: assert property (FUNCTION_SELECT == fas_pkg::FN_OR |-> f == (r | s))
        else $error("logic result wrong");
    chk_src_zero: assert property (SOURCE_SELECT == fas_pkg::SRC_D_Z |-> s == 4'h0)
        else $error("inhibited operand not zero");
    chk_shift_pins: assert property (up |-> RAM_SHIFT_MSB_OE && !RAM_SHIFT_LSB_OE)
        else $error("file shift pins wrong");
    chk_acc_pins: assert property (DESTINATION_SELECT == fas_pkg::FILE_SHIFT_UP
        |-> !ACC_SHIFT_MSB_OE && !ACC_SHIFT_LSB_OE)
        else $error("accumulator pins driven");
    chk_irq_level: assert property (IRQ == |(st.status & st.mask))
        else $error("interrupt level wrong");
    chk_gen_prop: assert property (FUNCTION_SELECT == fas_pkg::FN_ADD && !PROPAGATE_N
        && CARRY_IN |-> CARRY_OUT)
        else $error("propagate without carry");

    // Shifted loads; the far end bit comes from the neighbour
    chk_acc_up: assert property (
        DESTINATION_SELECT == fas_pkg::BOTH_SHIFT_UP
        |=> st.acc == {$past(st.acc[2:0]), $past(ACC_SHIFT_LSB_I)})
        else $error("accumulator up shift wrong");

    chk_file_up: assert property (
        up
        |=> st.file[$past(SECOND_ADDR)] == {$past(f[2:0]), $past(RAM_SHIFT_LSB_I)})
        else $error("file up shift wrong");

    chk_file_down: assert property (
        down
        |=> st.file[$past(SECOND_ADDR)] == {$past(RAM_SHIFT_MSB_I), $past(f[3:1])})
        else $error("file down shift wrong");

    chk_no_shift: assert property (
        DESTINATION_SELECT < fas_pkg::BOTH_SHIFT_DOWN
        |-> !RAM_SHIFT_MSB_OE && !RAM_SHIFT_LSB_OE)
        else $error("file pins driven without shift");

    chk_pin_down: assert property (
        down
        |-> RAM_SHIFT_LSB_OE && RAM_SHIFT_LSB_O == f[0])
        else $error("file low pin wrong");

    chk_acc_msb: assert property (
        DESTINATION_SELECT == fas_pkg::BOTH_SHIFT_UP
        |-> ACC_SHIFT_MSB_OE && ACC_SHIFT_MSB_O == st.acc[3])
        else $error("accumulator high pin wrong");

    // Subtracts against plain sums, independent of the chain logic
    chk_sub_rev: assert property (
        FUNCTION_SELECT == fas_pkg::REVERSE_SUBTRACT
        |-> {CARRY_OUT, f} == {1'b0, s} + {1'b0, ~r} + 5'(CARRY_IN))
        else $error("reverse subtract wrong");

    chk_sub_fwd: assert property (
        FUNCTION_SELECT == fas_pkg::FORWARD_SUBTRACT
        |-> {CARRY_OUT, f} == {1'b0, r} + {1'b0, ~s} + 5'(CARRY_IN))
        else $error("forward subtract wrong");

    // Logic codes must not see the carry
    chk_and_fn: assert property (
        FUNCTION_SELECT == fas_pkg::FN_AND
        |-> f == (r & s))
        else $error("and result wrong");

    chk_xnor_fn: assert property (
        FUNCTION_SELECT == fas_pkg::EXCLUSIVE_NOR_FN
        |-> f == ~(r ^ s))
        else $error("xnor result wrong");

    chk_src_da: assert property (
        SOURCE_SELECT == fas_pkg::SRC_D_A
        |-> r == DIRECT_DATA_IN && s == port_a)
        else $error("direct pair wrong");

    chk_src_zq: assert property (
        SOURCE_SELECT == fas_pkg::SRC_Z_ACC
        |-> r == 4'h0 && s == st.acc)
        else $error("zero pair wrong");


    cov_overflow: cover property (FUNCTION_SELECT == fas_pkg::FN_ADD && ovr_now);
    cov_down:     cover property (DESTINATION_SELECT == fas_pkg::BOTH_SHIFT_DOWN);
    cov_up:       cover property (DESTINATION_SELECT == fas_pkg::BOTH_SHIFT_UP);
    cov_irq:      cover property (!IRQ ##1 IRQ);
    cov_port:     cover property (DESTINATION_SELECT == fas_pkg::LOAD_FILE_SHOW_PORT);
endmodule : fas_slice

/* File: tb/fas_nbr.sv */
`timescale 1ns/1ps
// Neighbouring slices on the shift pins and the pulled-up zero line
module fas_nbr (
    input  wire logic clk,        // Slice clock
    input  wire logic ram_lsb_o,  // File low end out
    input  wire logic ram_lsb_oe, // File low end drive
    input  wire logic ram_msb_o,  // File high end out
    input  wire logic ram_msb_oe, // File high end drive
    input  wire logic acc_lsb_o,  // Accumulator low end out
    input  wire logic acc_lsb_oe, // Accumulator low end drive
    input  wire logic acc_msb_o,  // Accumulator high end out
    input  wire logic acc_msb_oe, // Accumulator high end drive
    input  wire logic zero_o,     // Zero line value
    input  wire logic zero_oe,    // Zero line pull-down
    output logic      ram_lsb_i,  // File low end level
    output logic      ram_msb_i,  // File high end level
    output logic      acc_lsb_i,  // Accumulator low end level
    output logic      acc_msb_i,  // Accumulator high end level
    output logic      zero_i      // Zero line level
);
    logic tog = 1'b0;
    // Neighbour bits change every cycle, so a stale end bit never passes by luck
    always_ff @(posedge clk) begin
        tog <= ~tog;
    end
    // Neighbour supplies the end bit whenever the slice releases a pin
    assign ram_lsb_i = ram_lsb_oe ? ram_lsb_o : tog;
    assign ram_msb_i = ram_msb_oe ? ram_msb_o : ~tog;
    assign acc_lsb_i = acc_lsb_oe ? acc_lsb_o : ~tog;
    assign acc_msb_i = acc_msb_oe ? acc_msb_o : tog;
    // Pull-up: the line is low only while a slice pulls it down
    assign zero_i = ~(zero_oe & ~zero_o);
endmodule : fas_nbr

/* File: tb/fas_slice_test.sv */
`timescale 1ns/1ps
module fas_slice_test;
    logic CLK = 1'b0, RST_N = 1'b0, CARRY_IN = 1'b0, OUT_ENABLE_N = 1'b1;
    logic [2:0] SOURCE_SELECT = 3'h7, FUNCTION_SELECT = 3'h3, DESTINATION_SELECT = 3'h1;
    logic [3:0] FIRST_READ_ADDR = 4'h0, SECOND_ADDR = 4'h0, DIRECT_DATA_IN = 4'hF, RESULT_O;
    logic [1:0] REG_ADDR = 2'h0;
    logic [7:0] REG_WDATA = 8'h00, REG_RDATA, v;
    logic REG_WR = 1'b0, REG_RD = 1'b0, RESULT_OE, CARRY_OUT, GENERATE_N, PROPAGATE_N, IRQ;
    logic OVERFLOW_FLAG, SIGN_BIT, ZERO_DETECT_I, ZERO_DETECT_O, ZERO_DETECT_OE;
    logic RAM_SHIFT_LSB_I, RAM_SHIFT_LSB_O, RAM_SHIFT_LSB_OE, RAM_SHIFT_MSB_I, RAM_SHIFT_MSB_O;
    logic RAM_SHIFT_MSB_OE, ACC_SHIFT_LSB_I, ACC_SHIFT_LSB_O, ACC_SHIFT_LSB_OE;
    logic ACC_SHIFT_MSB_I, ACC_SHIFT_MSB_O, ACC_SHIFT_MSB_OE;
    logic [3:0] mem [16];
    logic [3:0] acc;
    int fails = 0, checked = 0;
    fas_slice fas_slice_inst (.CLK(CLK), .RST_N(RST_N), .SOURCE_SELECT(SOURCE_SELECT),
        .FUNCTION_SELECT(FUNCTION_SELECT), .DESTINATION_SELECT(DESTINATION_SELECT),
        .FIRST_READ_ADDR(FIRST_READ_ADDR), .SECOND_ADDR(SECOND_ADDR),
        .DIRECT_DATA_IN(DIRECT_DATA_IN), .CARRY_IN(CARRY_IN), .OUT_ENABLE_N(OUT_ENABLE_N),
        .RESULT_O(RESULT_O), .RESULT_OE(RESULT_OE), .CARRY_OUT(CARRY_OUT),
        .GENERATE_N(GENERATE_N), .PROPAGATE_N(PROPAGATE_N), .OVERFLOW_FLAG(OVERFLOW_FLAG),
        .SIGN_BIT(SIGN_BIT), .ZERO_DETECT_I(ZERO_DETECT_I), .ZERO_DETECT_O(ZERO_DETECT_O),
        .ZERO_DETECT_OE(ZERO_DETECT_OE), .RAM_SHIFT_LSB_I(RAM_SHIFT_LSB_I),
        .RAM_SHIFT_LSB_O(RAM_SHIFT_LSB_O), .RAM_SHIFT_LSB_OE(RAM_SHIFT_LSB_OE),
        .RAM_SHIFT_MSB_I(RAM_SHIFT_MSB_I), .RAM_SHIFT_MSB_O(RAM_SHIFT_MSB_O),
        .RAM_SHIFT_MSB_OE(RAM_SHIFT_MSB_OE), .ACC_SHIFT_LSB_I(ACC_SHIFT_LSB_I),
        .ACC_SHIFT_LSB_O(ACC_SHIFT_LSB_O), .ACC_SHIFT_LSB_OE(ACC_SHIFT_LSB_OE),
        .ACC_SHIFT_MSB_I(ACC_SHIFT_MSB_I), .ACC_SHIFT_MSB_O(ACC_SHIFT_MSB_O),
        .ACC_SHIFT_MSB_OE(ACC_SHIFT_MSB_OE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .IRQ(IRQ));
    fas_nbr fas_nbr_inst (.clk(CLK), .ram_lsb_o(RAM_SHIFT_LSB_O), .ram_lsb_oe(RAM_SHIFT_LSB_OE),
        .ram_msb_o(RAM_SHIFT_MSB_O), .ram_msb_oe(RAM_SHIFT_MSB_OE), .acc_lsb_o(ACC_SHIFT_LSB_O),
        .acc_lsb_oe(ACC_SHIFT_LSB_OE), .acc_msb_o(ACC_SHIFT_MSB_O),
        .acc_msb_oe(ACC_SHIFT_MSB_OE), .zero_o(ZERO_DETECT_O), .zero_oe(ZERO_DETECT_OE),
        .ram_lsb_i(RAM_SHIFT_LSB_I), .ram_msb_i(RAM_SHIFT_MSB_I), .acc_lsb_i(ACC_SHIFT_LSB_I),
        .acc_msb_i(ACC_SHIFT_MSB_I), .zero_i(ZERO_DETECT_I));
    // 200 MHz clock
    initial begin
        forever #2.5 CLK = ~CLK;
    end
    // Reference result: {pn, gn, ovr, carry, f}
    function automatic logic [7:0] alu_ref(input logic [2:0] src, fn,
                                           input logic [3:0] a, b, d, q, input logic cin);
        logic [3:0] r, s, f;
        logic [4:0] sum, gen;
        logic [3:0] low;
        case (src)
            3'h0: begin r = a; s = q; end
            3'h1: begin r = a; s = b; end
            3'h2: begin r = 4'h0; s = q; end
            3'h3: begin r = 4'h0; s = b; end
            3'h4: begin r = 4'h0; s = a; end
            3'h5: begin r = d; s = a; end
            3'h6: begin r = d; s = q; end
            default: begin r = d; s = 4'h0; end
        endcase
        case (fn)
            3'h3: f = r | s;
            3'h4: f = r & s;
            3'h5: f = ~r & s;
            3'h6: f = r ^ s;
            3'h7: f = ~(r ^ s);
            default: f = 4'h0;
        endcase
        if (fn == 3'h1) r = ~r;
        if (fn == 3'h2) s = ~s;
        sum = {1'b0, r} + {1'b0, s} + {4'h0, cin};
        gen = {1'b0, r} + {1'b0, s};
        low = {1'b0, r[2:0]} + {1'b0, s[2:0]} + {3'h0, cin};
        if (fn < 3'h3) f = sum[3:0];
        return {~&(r | s), ~gen[4], sum[4] ^ low[3], sum[4], f};
    endfunction : alu_ref
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One microinstruction, then an idle cycle whose registered outputs describe it
    task automatic op(input logic [2:0] src, fn, dst, input logic [3:0] a, b, d,
                      input logic cin);
        logic [7:0] e;
        logic [3:0] f, y;
        @(posedge CLK);
        SOURCE_SELECT <= src;
        FUNCTION_SELECT <= fn;
        DESTINATION_SELECT <= dst;
        FIRST_READ_ADDR <= a;
        SECOND_ADDR <= b;
        DIRECT_DATA_IN <= d;
        CARRY_IN <= cin;
        @(negedge CLK);
        e = alu_ref(src, fn, mem[a], mem[b], d, acc, cin);
        f = e[3:0];
        y = (dst == 3'h2) ? mem[a] : f;
        if (fn < 3'h3) begin
            check({GENERATE_N, PROPAGATE_N, CARRY_OUT}, {e[6], e[7], e[4]});
        end
        check({RAM_SHIFT_LSB_OE, RAM_SHIFT_MSB_OE}, {dst[2] & ~dst[1], dst[2] & dst[1]});
        if (dst[2]) check(dst[1] ? RAM_SHIFT_MSB_O : RAM_SHIFT_LSB_O, dst[1] ? f[3] : f[0]);
        check({ACC_SHIFT_LSB_OE, ACC_SHIFT_MSB_OE}, {dst == 3'h4, dst == 3'h6});
        if (dst == 3'h4) check(ACC_SHIFT_LSB_O, acc[0]);
        if (dst == 3'h6) check(ACC_SHIFT_MSB_O, acc[3]);
        case (dst)
            3'h0: acc = f;
            3'h2, 3'h3: mem[b] = f;
            3'h4, 3'h5: mem[b] = {RAM_SHIFT_MSB_I, f[3:1]};
            3'h6, 3'h7: mem[b] = {f[2:0], RAM_SHIFT_LSB_I};
            default: ;
        endcase
        if (dst == 3'h4) acc = {ACC_SHIFT_MSB_I, acc[3:1]};
        if (dst == 3'h6) acc = {acc[2:0], ACC_SHIFT_LSB_I};
        @(posedge CLK);
        DESTINATION_SELECT <= 3'h1;
        SOURCE_SELECT <= 3'h7;
        FUNCTION_SELECT <= 3'h3;
        DIRECT_DATA_IN <= 4'hF;
        CARRY_IN <= 1'b0;
        @(negedge CLK);
        check(RESULT_O, y);
        check({RESULT_OE, SIGN_BIT}, {~OUT_ENABLE_N, f[3]});
        check({ZERO_DETECT_OE, ZERO_DETECT_I}, {f != 4'h0, f == 4'h0});
        if (fn < 3'h3) check(OVERFLOW_FLAG, e[5]);
    endtask : op
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge CLK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge CLK);
        REG_WR <= 1'b0;
    endtask : wr
    task automatic rd(input logic [1:0] a, output logic [7:0] q);
        @(posedge CLK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge CLK);
        REG_RD <= 1'b0;
        @(negedge CLK);
        q = REG_RDATA;
    endtask : rd
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : close_out
    // Hang guard
    initial begin
        repeat (50000) @(posedge CLK);
        fails++;
        close_out();
    end
    // Main sequence: reset, file fill, full operand and function sweep, destinations, registers
    initial begin
        foreach (mem[i]) mem[i] = 4'h0;
        acc = 4'h0;
        repeat (20) @(posedge CLK);
        RST_N <= 1'b1;
        repeat (3) @(posedge CLK);
        @(negedge CLK);
        check({RESULT_OE, IRQ}, 8'h00);
        rd(fas_pkg::OFS_MASK, v);
        check(v, 8'h00);
        @(posedge CLK);
        OUT_ENABLE_N <= 1'b0;
        for (int i = 0; i < 16; i++) op(3'h7, 3'h3, 3'h3, 4'h0, 4'(i), 4'(i * 7 + 3), 1'b0);
        op(3'h7, 3'h3, 3'h0, 4'h0, 4'h0, 4'h6, 1'b0);
        for (int s = 0; s < 8; s++)
            for (int fn = 0; fn < 8; fn++)
                for (int c = 0; c < 2; c++)
                    op(3'(s), 3'(fn), 3'h1, 4'(s + c), 4'(fn + 8), 4'(s * 5 + fn), 1'(c));
        for (int dd = 0; dd < 8; dd++) begin
            op(3'h1, 3'(dd), 3'(dd), 4'h2, 4'(dd + 4), 4'h0, 1'(dd));
            op(3'h3, 3'h3, 3'h1, 4'h0, 4'(dd + 4), 4'h0, 1'b0);
            op(3'h4, 3'h3, 3'h1, 4'h2, 4'h0, 4'h0, 1'b0);
            op(3'h2, 3'h3, 3'h1, 4'h0, 4'h0, 4'h0, 1'b0);
        end
        op(3'h1, 3'h6, 3'h2, 4'h7, 4'h7, 4'h0, 1'b0);
        @(posedge CLK);
        OUT_ENABLE_N <= 1'b1;
        op(3'h7, 3'h3, 3'h1, 4'h0, 4'h0, 4'h9, 1'b0);
        rd(fas_pkg::OFS_STATE, v);
        check(v[3:0], acc);
        wr(fas_pkg::OFS_STATE, 8'hFF);
        rd(fas_pkg::OFS_STATE, v);
        check(v[3:0], acc);
        wr(2'h3, 8'hFF);
        rd(2'h3, v);
        check(v, 8'h00);
        wr(fas_pkg::OFS_STATUS, 8'h07);
        rd(fas_pkg::OFS_STATUS, v);
        check(v, 8'h00);
        wr(fas_pkg::OFS_MASK, 8'h04);
        op(3'h7, 3'h0, 3'h1, 4'h0, 4'h0, 4'hF, 1'b1);
        rd(fas_pkg::OFS_STATUS, v);
        check(v, 8'h06);
        check(IRQ, 1'b1);
        wr(fas_pkg::OFS_MASK, 8'h01);
        rd(fas_pkg::OFS_MASK, v);
        check(v, 8'h01);
        check(IRQ, 1'b0);
        wr(fas_pkg::OFS_MASK, 8'h04);
        wr(fas_pkg::OFS_STATUS, 8'h04);
        rd(fas_pkg::OFS_STATUS, v);
        check(v, 8'h02);
        check(IRQ, 1'b0);
        close_out();
    end
endmodule : fas_slice_test
